// File: baud_pkg.sv
package baud_pkg;

  // ==========================================================
  // register map (plain port)
  // ==========================================================
  localparam int ADDR_W = 3;
  localparam logic [2:0] ADDR_DIV_LOW = 3'h0;
  localparam logic [2:0] ADDR_DIV_HIGH = 3'h1;
  localparam logic [2:0] ADDR_MODEM_CTRL = 3'h2;
  localparam logic [2:0] ADDR_ENH_FEAT = 3'h3;
  localparam logic [2:0] ADDR_ICR_INDEX = 3'h4;
  localparam logic [2:0] ADDR_ICR_DATA = 3'h5;

  // indexed control set
  localparam logic [7:0] IDX_PRESCALER = 8'h01;
  localparam logic [7:0] IDX_OVERSAMPLE = 8'h02;
  localparam logic [7:0] IDX_CLOCK_SEL = 8'h03;

  // ==========================================================
  // field positions
  // ==========================================================
  localparam int PRESCALER_EN_BIT = 7;
  localparam int ENH_MODE_BIT = 4;
  localparam int TX_ISO_BIT = 7;
  localparam int RX_ISO_BIT = 3;
  localparam int MCR_LOCK_LSB = 5;

  // ==========================================================
  // values after reset
  // ==========================================================
  localparam logic [7:0] DIV_LOW_RESET = 8'h01;
  localparam logic [7:0] DIV_HIGH_RESET = 8'h00;
  localparam logic [7:0] MODEM_CTRL_RESET = 8'h00;
  localparam logic [7:0] ENH_FEAT_RESET = 8'h00;
  localparam logic [7:0] ICR_INDEX_RESET = 8'h00;
  localparam logic [7:0] PRESCALER_RESET = 8'h08;
  localparam logic [3:0] OVERSAMPLE_RESET = 4'h0;
  localparam logic [7:0] CLOCK_SEL_RESET = 8'h00;

  // ==========================================================
  // counts
  // ==========================================================
  localparam logic [4:0] DEFAULT_SAMPLES = 5'h10;
  localparam int FRAC_STEPS = 8;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wrData;
    logic write;
    logic read;
  } regReq_s;

endpackage : baud_pkg

// File: tb_uart_baud_rate_generator.sv
`timescale 1ns/1ns
module tb_uart_baud_rate_generator;
  import baud_pkg::*;
  logic clk_sys;
  logic reset_n;
  logic clkEnable;
  regReq_s regReq;
  logic [7:0] regRdData;
  logic txSampleTick;
  logic rxSampleTick;
  logic txBitTick;
  logic rxBitTick;
  logic txIsochronous;
  logic rxIsochronous;
  int badCount;
  int checks;

  uart_baud_rate_generator i_dut (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clkEnable(clkEnable),
    .regReq(regReq),
    .regRdData(regRdData),
    .txSampleTick(txSampleTick),
    .rxSampleTick(rxSampleTick),
    .txBitTick(txBitTick),
    .rxBitTick(rxBitTick),
    .txIsochronous(txIsochronous),
    .rxIsochronous(rxIsochronous)
  );

  // ==========================================================
  // clock, verdict and comparison
  // ==========================================================
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic test_done();
    if (badCount == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      badCount++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  // ==========================================================
  // register port
  // ==========================================================
  task automatic wr(input logic [2:0] addr, input logic [7:0] data);
    @(posedge clk_sys);
    regReq.addr <= addr;
    regReq.wrData <= data;
    regReq.write <= 1'b1;
    @(posedge clk_sys);
    regReq.write <= 1'b0;
  endtask : wr

  // read data stand one cycle only, then return to zero
  task automatic rd(input logic [2:0] addr, input logic [7:0] exp, input string name);
    @(posedge clk_sys);
    regReq.addr <= addr;
    regReq.read <= 1'b1;
    @(posedge clk_sys);
    regReq.read <= 1'b0;
    #1;
    check(name, {24'h0, regRdData}, {24'h0, exp});
    @(posedge clk_sys);
    #1;
    check("read data idle", {24'h0, regRdData}, 32'h0);
  endtask : rd

  task automatic idxWr(input logic [7:0] idx, input logic [7:0] data);
    wr(ADDR_ICR_INDEX, idx);
    wr(ADDR_ICR_DATA, data);
  endtask : idxWr

  task automatic idxRd(input logic [7:0] idx, input logic [7:0] exp, input string name);
    wr(ADDR_ICR_INDEX, idx);
    rd(ADDR_ICR_DATA, exp, name);
  endtask : idxRd

  // ==========================================================
  // tick timing
  // ==========================================================
  function automatic logic tickOf(input int which);
    case (which)
      0: return txSampleTick;
      1: return txBitTick;
      2: return rxSampleTick;
      default: return rxBitTick;
    endcase
  endfunction : tickOf

  task automatic waitTick(input int which, output int cyc);
    cyc = 0;
    do
    begin
      @(posedge clk_sys);
      #1;
      cyc++;
    end while (tickOf(which) !== 1'b1 && cyc < 3000);
    if (cyc >= 3000)
    begin
      check("tick timeout", 32'h1, 32'h0);
      test_done();
    end
  endtask : waitTick

  // the first two ticks only resynchronise after a mid-count change
  task automatic gapCheck(input string name, input int which, input int exp);
    int g;
    waitTick(which, g);
    waitTick(which, g);
    waitTick(which, g);
    check(name, g, exp);
  endtask : gapCheck

  task automatic countTicks(input int which, input int exp);
    int n;
    n = 0;
    repeat (40)
    begin
      @(posedge clk_sys);
      #1;
      if (tickOf(which) !== 1'b0)
        n++;
    end
    check("ticks in iso", n, exp);
  endtask : countTicks

  // ==========================================================
  // scenarios
  // ==========================================================
  task automatic tResetDefaults();
    rd(ADDR_DIV_LOW, 8'h01, "divisor low");
    rd(ADDR_DIV_HIGH, 8'h00, "divisor high");
    idxRd(IDX_PRESCALER, 8'h08, "prescaler");
    idxRd(IDX_OVERSAMPLE, 8'h00, "oversample reset");
    gapCheck("tx sample gap", 0, 1);
    gapCheck("tx bit gap", 1, 16);
    gapCheck("rx bit gap", 3, 16);
  endtask : tResetDefaults

  // runs before enhanced mode is switched on
  task automatic tOversample();
    logic [7:0] v;
    int s;
    wr(ADDR_DIV_LOW, 8'h02);
    for (int i = 0; i < 19; i++)
    begin
      v = (i < 16) ? {4'ha, 4'(i)} : (i == 16) ? 8'h01 : (i == 17) ? 8'h10 : 8'h11;
      s = (v[3:0] < 4) ? 16 : int'(v[3:0]);
      idxWr(IDX_OVERSAMPLE, v);
      idxRd(IDX_OVERSAMPLE, {4'h0, v[3:0]}, "oversample read");
      gapCheck("bit gap per code", 1, 2 * s);
      check("no iso from code", {31'h0, txIsochronous}, 32'h0);
    end
  endtask : tOversample

  task automatic tDivisor();
    wr(ADDR_DIV_LOW, 8'h03);
    gapCheck("divisor 3", 0, 3);
    wr(ADDR_DIV_HIGH, 8'h01);
    wr(ADDR_DIV_LOW, 8'h01);
    gapCheck("divisor 257", 2, 257);
    rd(ADDR_DIV_HIGH, 8'h01, "divisor high back");
    wr(ADDR_DIV_HIGH, 8'h00);
  endtask : tDivisor

  task automatic tPrescaler();
    idxWr(IDX_PRESCALER, 8'h11);
    wr(ADDR_MODEM_CTRL, 8'h83);
    rd(ADDR_MODEM_CTRL, 8'h03, "modem ctrl locked");
    gapCheck("bypassed", 1, 16);
    wr(ADDR_ENH_FEAT, 8'h10);
    wr(ADDR_MODEM_CTRL, 8'h80);
    rd(ADDR_MODEM_CTRL, 8'h80, "modem ctrl open");
    gapCheck("ratio 2.125", 1, 34);
    idxWr(IDX_PRESCALER, 8'hff);
    idxRd(IDX_PRESCALER, 8'hff, "prescaler read");
    idxWr(IDX_OVERSAMPLE, 8'h08);
    gapCheck("ratio 31.875", 3, 255);
    wr(ADDR_MODEM_CTRL, 8'h00);
    gapCheck("bypass again", 1, 8);
  endtask : tPrescaler

  task automatic tIso();
    idxWr(IDX_CLOCK_SEL, 8'h80);
    repeat (2) @(posedge clk_sys);
    #1;
    check("tx iso", {30'h0, txIsochronous, rxIsochronous}, 32'h2);
    countTicks(0, 0);
    gapCheck("rx unaffected", 3, 8);
    idxWr(IDX_CLOCK_SEL, 8'h08);
    repeat (2) @(posedge clk_sys);
    #1;
    check("rx iso", {30'h0, txIsochronous, rxIsochronous}, 32'h1);
    countTicks(3, 0);
    gapCheck("tx unaffected", 1, 8);
    idxWr(IDX_CLOCK_SEL, 8'h00);
    rd(3'h6, 8'h00, "unmapped");
    idxRd(8'h07, 8'h00, "unmapped index");
  endtask : tIso

  // a low enable must hold the read data and drop a write strobe
  task automatic tFreeze();
    wr(ADDR_DIV_LOW, 8'h04);
    @(posedge clk_sys);
    regReq.addr <= ADDR_DIV_LOW;
    regReq.read <= 1'b1;
    @(posedge clk_sys);
    regReq.read <= 1'b0;
    clkEnable <= 1'b0;
    regReq.wrData <= 8'h09;
    regReq.write <= 1'b1;
    @(posedge clk_sys);
    regReq.write <= 1'b0;
    repeat (2) @(posedge clk_sys);
    clkEnable <= 1'b1;
    #1;
    check("frozen read data", {24'h0, regRdData}, 32'h4);
    rd(ADDR_DIV_LOW, 8'h04, "write while frozen");
    gapCheck("bit gap after freeze", 1, 32);
    wr(ADDR_DIV_LOW, 8'h01);
  endtask : tFreeze

  task automatic tSecondReset();
    wr(ADDR_MODEM_CTRL, 8'h80);
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    idxRd(IDX_OVERSAMPLE, 8'h00, "oversample after reset");
    gapCheck("bit gap after reset", 1, 16);
  endtask : tSecondReset

  initial
  begin
    badCount = 0;
    checks = 0;
    reset_n = 1'b0;
    clkEnable = 1'b1;
    regReq = '0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    tResetDefaults();
    tOversample();
    tDivisor();
    tPrescaler();
    tIso();
    tFreeze();
    tSecondReset();
    test_done();
  end
endmodule : tb_uart_baud_rate_generator

// File: uart_baud_rate_generator.sv
`timescale 1ns/1ns
// Functional notes
// - divide by 16-bit divisor 1..65535, low byte plus 256 times high byte
// - bit rate equals clock over samples times divisor times prescaler
// - enabled prescaler divides by M+N/8, M bits 7:3, N bits 2:0
// - prescaler-enable clear means divide by one regardless of ratio
// - after reset prescaler bypassed and oversample register zero, 16 per bit
// - oversample codes 0..3 give 16, codes 4..15 give their value
// - oversample bits 7:4 unused and read as zero
// - oversample reads return last written low nibble in every mode
// - writing 0x01, 0x10 or 0x11 gives 16x, never isochronous
// - isochronous path ignores sampling setting; its ticks are held off
// - oversample setting works with or without enhanced mode
// - prescaler-enable writable only in enhanced mode; software sets enhanced first
// - prescaler ratio sits at index 0x01 of indexed set
// - oversample count sits at index 0x02 of indexed set
// - chain correct for any reference clock 1.8432 to 60 MHz
// - tx and rx enter isochronous by clock-select bits 7 and 3
// - modem-control bits 7:5 ignore writes while enhanced mode is off
module uart_baud_rate_generator (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clkEnable,
  input wire baud_pkg::regReq_s regReq,
  output logic [7:0] regRdData,
  output logic txSampleTick,
  output logic rxSampleTick,
  output logic txBitTick,
  output logic rxBitTick,
  output logic txIsochronous,
  output logic rxIsochronous
);
  import baud_pkg::*;

  // ==========================================================
  // registers
  // ==========================================================
  logic [7:0] divisorLow;
  logic [7:0] divisorHigh;
  logic [7:0] modemControl;
  logic [7:0] enhancedFeatures;
  logic [7:0] icrIndex;
  logic [7:0] prescalerRatio;
  logic [3:0] oversampleCount;
  logic [7:0] clockSelect;
  logic wrEn;
  logic rdEn;
  logic icrWrite;
  logic enhancedMode;
  logic prescalerEnable;

  assign wrEn = regReq.write && clkEnable;
  assign rdEn = regReq.read && clkEnable;
  assign icrWrite = wrEn && (regReq.addr == ADDR_ICR_DATA);
  assign enhancedMode = enhancedFeatures[ENH_MODE_BIT];
  assign prescalerEnable = modemControl[PRESCALER_EN_BIT];

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      divisorLow <= DIV_LOW_RESET;
      divisorHigh <= DIV_HIGH_RESET;
      enhancedFeatures <= ENH_FEAT_RESET;
      icrIndex <= ICR_INDEX_RESET;
    end
    else if (wrEn)
    begin
      case (regReq.addr)
        ADDR_DIV_LOW: divisorLow <= regReq.wrData;
        ADDR_DIV_HIGH: divisorHigh <= regReq.wrData;
        ADDR_ENH_FEAT: enhancedFeatures <= regReq.wrData;
        ADDR_ICR_INDEX: icrIndex <= regReq.wrData;
        default: ;
      endcase
    end
  end

  // upper modem bits locked outside enhanced mode
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      modemControl <= MODEM_CTRL_RESET;
    else if (wrEn && regReq.addr == ADDR_MODEM_CTRL)
    begin
      modemControl[MCR_LOCK_LSB-1:0] <= regReq.wrData[MCR_LOCK_LSB-1:0];
      if (enhancedMode)
        modemControl[7:MCR_LOCK_LSB] <= regReq.wrData[7:MCR_LOCK_LSB];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prescalerRatio <= PRESCALER_RESET;
      oversampleCount <= OVERSAMPLE_RESET;
      clockSelect <= CLOCK_SEL_RESET;
    end
    else if (icrWrite)
    begin
      case (icrIndex)
        IDX_PRESCALER: prescalerRatio <= regReq.wrData;
        IDX_OVERSAMPLE: oversampleCount <= regReq.wrData[3:0];
        IDX_CLOCK_SEL: clockSelect <= regReq.wrData;
        default: ;
      endcase
    end
  end

  // read data valid in the cycle after the strobe, and held while the enable is low
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      regRdData <= 8'h00;
    else if (!clkEnable)
      regRdData <= regRdData;
    else if (!regReq.read)
      regRdData <= 8'h00;
    else
    begin
      case (regReq.addr)
        ADDR_DIV_LOW: regRdData <= divisorLow;
        ADDR_DIV_HIGH: regRdData <= divisorHigh;
        ADDR_MODEM_CTRL: regRdData <= modemControl;
        ADDR_ENH_FEAT: regRdData <= enhancedFeatures;
        ADDR_ICR_INDEX: regRdData <= icrIndex;
        ADDR_ICR_DATA:
        begin
          case (icrIndex)
            IDX_PRESCALER: regRdData <= prescalerRatio;
            IDX_OVERSAMPLE: regRdData <= {4'h0, oversampleCount};
            IDX_CLOCK_SEL: regRdData <= clockSelect;
            default: regRdData <= 8'h00;
          endcase
        end
        default: regRdData <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // fractional prescaler
  // ==========================================================
  // M of zero is taken as one so the chain never stalls
  logic [5:0] mInt;
  logic [2:0] nFrac;
  logic [2:0] fracAcc;
  logic [3:0] fracSum;
  logic [5:0] prePeriod;
  logic [5:0] preCount;
  logic preTick;

  assign mInt = (prescalerRatio[7:3] == 5'h00) ? 6'h01 : {1'b0, prescalerRatio[7:3]};
  assign nFrac = prescalerRatio[2:0];
  assign fracSum = {1'b0, fracAcc} + {1'b0, nFrac};
  assign prePeriod = mInt + {5'h00, fracSum[3]};
  assign preTick = clkEnable && (!prescalerEnable || preCount >= prePeriod - 6'h01);

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      preCount <= 6'h00;
      fracAcc <= 3'h0;
    end
    else if (clkEnable)
    begin
      if (!prescalerEnable)
      begin
        preCount <= 6'h00;
        fracAcc <= 3'h0;
      end
      else if (preTick)
      begin
        preCount <= 6'h00;
        fracAcc <= fracSum[2:0];
      end
      else
        preCount <= preCount + 6'h01;
    end
  end

  // ==========================================================
  // divisor latch stage
  // ==========================================================
  // a divisor of zero is outside the legal range and stops the ticks
  logic [15:0] divisor;
  logic [15:0] divCount;
  logic divTick;

  assign divisor = {divisorHigh, divisorLow};
  assign divTick = preTick && (divisor != 16'h0000) && (divCount >= divisor - 16'h0001);

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      divCount <= 16'h0000;
    else if (preTick)
    begin
      if (divTick || divisor == 16'h0000)
        divCount <= 16'h0000;
      else
        divCount <= divCount + 16'h0001;
    end
  end

  // ==========================================================
  // oversampling stage
  // ==========================================================
  logic [4:0] samplesPerBit;
  logic [4:0] sampleCount;
  logic bitTick;

  // codes below four, including 0x01, fall back to 16x
  assign samplesPerBit = (oversampleCount[3:2] == 2'b00) ?
    DEFAULT_SAMPLES : {1'b0, oversampleCount};
  assign bitTick = divTick && (sampleCount >= samplesPerBit - 5'h01);

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      sampleCount <= 5'h00;
    else if (divTick)
    begin
      if (bitTick)
        sampleCount <= 5'h00;
      else
        sampleCount <= sampleCount + 5'h01;
    end
  end

  // ==========================================================
  // outputs
  // ==========================================================
  // isochronous paths run on their 1x clock elsewhere, so their ticks stay low
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      txSampleTick <= 1'b0;
      rxSampleTick <= 1'b0;
      txBitTick <= 1'b0;
      rxBitTick <= 1'b0;
      txIsochronous <= 1'b0;
      rxIsochronous <= 1'b0;
    end
    else if (clkEnable)
    begin
      txIsochronous <= clockSelect[TX_ISO_BIT];
      rxIsochronous <= clockSelect[RX_ISO_BIT];
      txSampleTick <= divTick && !clockSelect[TX_ISO_BIT];
      rxSampleTick <= divTick && !clockSelect[RX_ISO_BIT];
      txBitTick <= bitTick && !clockSelect[TX_ISO_BIT];
      rxBitTick <= bitTick && !clockSelect[RX_ISO_BIT];
    end
  end

  // ==========================================================
  // checking helpers
  // ==========================================================
  // gaps are only trusted once a full bit passes with no register write
  logic cfgDirty;
  logic [5:0] preGap;
  logic [16:0] divGap;
  logic [4:0] sampleGap;
  logic [31:0] clockGap;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      cfgDirty <= 1'b1;
    else if (wrEn)
      cfgDirty <= 1'b1;
    else if (bitTick)
      cfgDirty <= 1'b0;
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      preGap <= 6'h01;
      clockGap <= 32'h0000_0001;
    end
    else if (clkEnable)
    begin
      preGap <= preTick ? 6'h01 : preGap + 6'h01;
      clockGap <= bitTick ? 32'h0000_0001 : clockGap + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      divGap <= 17'h0_0001;
      sampleGap <= 5'h01;
    end
    else
    begin
      if (divTick)
        divGap <= 17'h0_0001;
      else if (preTick)
        divGap <= divGap + 17'h0_0001;
      if (bitTick)
        sampleGap <= 5'h01;
      else if (divTick)
        sampleGap <= sampleGap + 5'h01;
    end
  end

  // ==========================================================
  // assertions
  // ==========================================================
  property p_bypass_every_cycle;
    @(posedge clk_sys) disable iff (!reset_n)
    (clkEnable && !prescalerEnable && divisor == 16'h0001 && !clockSelect[TX_ISO_BIT]) |=> txSampleTick;
  endproperty
  a_bypass_every_cycle: assert property (p_bypass_every_cycle)
    else $error("bypassed prescaler missed a cycle");

  property p_prescale_gap;
    @(posedge clk_sys) disable iff (!reset_n)
    (preTick && prescalerEnable && !cfgDirty) |->
      (preGap >= mInt) && (preGap <= mInt + 6'h01) && (nFrac != 3'h0 || preGap == mInt);
  endproperty
  a_prescale_gap: assert property (p_prescale_gap)
    else $error("prescaler period is not M or M+1");

  property p_divisor_gap;
    @(posedge clk_sys) disable iff (!reset_n)
    (divTick && !cfgDirty) |-> divGap == {1'b0, divisor};
  endproperty
  a_divisor_gap: assert property (p_divisor_gap)
    else $error("sample tick spacing differs from divisor");

  property p_samples_gap;
    @(posedge clk_sys) disable iff (!reset_n)
    (bitTick && !cfgDirty) |-> sampleGap == samplesPerBit;
  endproperty
  a_samples_gap: assert property (p_samples_gap)
    else $error("bit tick spacing differs from sample count");

  property p_low_codes_16x;
    @(posedge clk_sys) disable iff (!reset_n)
    (bitTick && !cfgDirty && oversampleCount[3:2] == 2'b00) |-> sampleGap == 5'h10;
  endproperty
  a_low_codes_16x: assert property (p_low_codes_16x)
    else $error("low oversample code did not give 16");

  property p_bit_rate;
    @(posedge clk_sys) disable iff (!reset_n)
    (bitTick && !cfgDirty && (!prescalerEnable || nFrac == 3'h0)) |->
      clockGap == 32'(samplesPerBit) * 32'(divisor) * (prescalerEnable ? 32'(mInt) : 32'd1);
  endproperty
  a_bit_rate: assert property (p_bit_rate)
    else $error("bit period is not samples times divisor times prescaler");

  property p_tcr_read;
    @(posedge clk_sys) disable iff (!reset_n)
    (rdEn && regReq.addr == ADDR_ICR_DATA && icrIndex == IDX_OVERSAMPLE) |=>
      regRdData == {4'h0, $past(oversampleCount)};
  endproperty
  a_tcr_read: assert property (p_tcr_read)
    else $error("oversample read does not match last write");

  property p_tcr_upper_zero;
    @(posedge clk_sys) disable iff (!reset_n)
    (rdEn && regReq.addr == ADDR_ICR_DATA && icrIndex == IDX_OVERSAMPLE) |=>
      regRdData[7:4] == 4'h0;
  endproperty
  a_tcr_upper_zero: assert property (p_tcr_upper_zero)
    else $error("oversample upper nibble not zero");

  property p_mcr_locked;
    @(posedge clk_sys) disable iff (!reset_n)
    (wrEn && regReq.addr == ADDR_MODEM_CTRL && !enhancedMode) |=>
      $stable(modemControl[7:5]);
  endproperty
  a_mcr_locked: assert property (p_mcr_locked)
    else $error("locked modem bits changed outside enhanced mode");

  property p_iso_quiet;
    @(posedge clk_sys) disable iff (!reset_n)
    (txIsochronous && $stable(txIsochronous)) |-> !txBitTick && !txSampleTick;
  endproperty
  a_iso_quiet: assert property (p_iso_quiet)
    else $error("tick seen on isochronous transmit path");

endmodule : uart_baud_rate_generator
